// File: vtpc_top.sv
// video test pattern generator control, timing, colour and apb register window
`timescale 1ns/1ps
`default_nettype none
module vtpc_top
  import vtpc_pkg::*;
(
  input  wire logic              CORE_CLK,
  input  wire logic              RST,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic [31:0]            PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  input  wire logic              PIX_CE,
  input  wire vtpc_video_t       VID_IN,
  output vtpc_video_t            VID_O
);
  // ==========================================================================
  // apb decode
  logic [7:0]  idx;
  logic        setup;
  logic        acc;
  logic        wr;
  logic        hit;
  logic [7:0]  en_reg_r;
  logic [7:0]  cfg_r;
  logic [7:0]  iaddr_r;
  logic [7:0]  ir_r [IR_DEPTH];
  logic [7:0]  prdata_r;
  logic [2:0]  cur_r;
  logic        iaddr_ok;

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    logic [7:0] i;
    i = a[9:2];
    if (a[ADDR_W-1:10] != '0 || a[1:0] != 2'b00) begin
      return 1'b0;
    end else if (i == IDX_ENABLE || i == IDX_CONFIG) begin
      return 1'b1;
    end else if (i == IDX_IADDR || i == IDX_IDATA) begin
      return 1'b1;
    end else begin
      return 1'b0;
    end
  endfunction : is_mapped

  assign idx      = PADDR[9:2];
  assign setup    = PSEL & ~PENABLE;
  assign acc      = PSEL & PENABLE;
  assign hit      = is_mapped(PADDR);
  assign wr       = acc & PWRITE & hit;
  assign PREADY   = 1'b1;
  assign PSLVERR  = acc & ~hit;
  assign PRDATA   = {24'h000000, prdata_r};
  assign iaddr_ok = iaddr_r < 8'(IR_DEPTH);

  logic wr_en;
  logic wr_cfg;
  logic wr_iaddr;
  logic wr_idata;
  logic psel_wr;
  assign wr_en    = wr & (idx == IDX_ENABLE);
  assign wr_cfg   = wr & (idx == IDX_CONFIG);
  assign wr_iaddr = wr & (idx == IDX_IADDR);
  assign wr_idata = wr & (idx == IDX_IDATA);
  assign psel_wr  = wr_idata & (iaddr_r == IR_PSEL);

  logic en;
  logic b18;
  logic extclk;
  logic tsel;
  logic inv;
  logic scroll;
  assign en     = en_reg_r[EN_BIT];
  assign b18    = cfg_r[CFG_B18];
  assign extclk = cfg_r[CFG_EXTCLK];
  assign tsel   = cfg_r[CFG_TSEL];
  assign inv    = cfg_r[CFG_INV];
  assign scroll = cfg_r[CFG_SCROLL];

  // ==========================================================================
  // direct registers
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      en_reg_r <= {7'h00, RST_ENABLE};
      cfg_r    <= RST_CONFIG;
    end else begin
      if (wr_en) begin
        en_reg_r <= {7'h00, PWDATA[EN_BIT]};
      end
      if (wr_cfg) begin
        cfg_r <= PWDATA[7:0] & CFG_MASK;
      end
    end
  end

  // data accesses never touch the address, so a burst of data writes hits one location
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      iaddr_r <= RST_IADDR;
    end else if (wr_iaddr) begin
      iaddr_r <= PWDATA[7:0];
    end
  end

  // ==========================================================================
  // indirect register array
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      ir_r <= IR_RST;
    end else if (wr_idata && iaddr_ok) begin
      ir_r[iaddr_r[3:0]] <= PWDATA[7:0];
    end
  end

  // read data is captured in the setup phase, so the access phase needs no wait state
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      prdata_r <= 8'h00;
    end else if (setup && !PWRITE) begin
      if (!hit) begin
        prdata_r <= 8'h00;
      end else if (idx == IDX_ENABLE) begin
        prdata_r <= en_reg_r;
      end else if (idx == IDX_CONFIG) begin
        prdata_r <= cfg_r;
      end else if (idx == IDX_IADDR) begin
        prdata_r <= iaddr_r;
      end else if (iaddr_r == IR_PSEL) begin
        prdata_r <= {5'h00, cur_r};
      end else if (iaddr_ok) begin
        prdata_r <= ir_r[iaddr_r[3:0]];
      end else begin
        prdata_r <= 8'h00;
      end
    end
  end

  // ==========================================================================
  // generator clock: divided enable or pixel strobe
  logic [7:0] div_r;
  logic       div_ce;
  logic       gen_ce;
  assign div_ce = div_r == DIV_LAST;
  assign gen_ce = tsel ? (extclk ? PIX_CE : div_ce) : PIX_CE;

  always_ff @(posedge CORE_CLK) begin
    if (RST || div_ce) begin
      div_r <= 8'h00;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end

  // ==========================================================================
  // internal timing
  logic [7:0] hc_r;
  logic [7:0] vc_r;
  logic       h_end;
  logic       v_end;
  logic [8:0] h_start;
  logic [8:0] v_start;

  function automatic logic in_win(input logic [7:0] c, input logic [8:0] s,
                                  input logic [7:0] len);
    logic [9:0] e;
    e = {1'b0, s} + {2'b00, len};
    return ({2'b00, c} >= {1'b0, s}) && ({2'b00, c} < e);
  endfunction : in_win

  assign h_end   = hc_r == ir_r[IR_HTOT[3:0]] - 8'h01;
  assign v_end   = vc_r == ir_r[IR_VTOT[3:0]] - 8'h01;
  assign h_start = {1'b0, ir_r[IR_HSW[3:0]]} + {1'b0, ir_r[IR_HBP[3:0]]};
  assign v_start = {1'b0, ir_r[IR_VSW[3:0]]} + {1'b0, ir_r[IR_VBP[3:0]]};

  always_ff @(posedge CORE_CLK) begin
    if (RST || !tsel) begin
      hc_r <= 8'h00;
      vc_r <= 8'h00;
    end else if (gen_ce) begin
      if (h_end) begin
        hc_r <= 8'h00;
        vc_r <= v_end ? 8'h00 : vc_r + 8'h01;
      end else begin
        hc_r <= hc_r + 8'h01;
      end
    end
  end

  logic int_de;
  logic int_hs;
  logic int_vs;
  logic [7:0] int_x;
  assign int_de = in_win(hc_r, h_start, ir_r[IR_HACT[3:0]])
                & in_win(vc_r, v_start, ir_r[IR_VACT[3:0]]);
  assign int_hs = (hc_r < ir_r[IR_HSW[3:0]]) ^ ir_r[IR_SPOL[3:0]][0];
  assign int_vs = (vc_r < ir_r[IR_VSW[3:0]]) ^ ir_r[IR_SPOL[3:0]][1];
  assign int_x  = hc_r - h_start[7:0];

  // ==========================================================================
  // external timing tracking
  logic [7:0] ext_x_r;
  logic       vs_prev_r;
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      ext_x_r   <= 8'h00;
      vs_prev_r <= 1'b0;
    end else if (gen_ce) begin
      ext_x_r   <= VID_IN.de ? ext_x_r + 8'h01 : 8'h00;
      vs_prev_r <= VID_IN.vs;
    end
  end

  logic frame_tick;
  assign frame_tick = gen_ce & (tsel ? (h_end & v_end) : (VID_IN.vs & ~vs_prev_r));

  // ==========================================================================
  // pattern selection and auto-scroll
  function automatic logic [2:0] next_pat(input logic [2:0] c, input logic [7:0] m);
    logic [2:0] n;
    logic [2:0] res;
    logic       found;
    res   = c;
    found = 1'b0;
    n     = c;
    for (int i = 0; i < NPAT; i++) begin
      n = (n == 3'(NPAT - 1)) ? 3'h0 : n + 3'h1;
      if (!found && m[n]) begin
        res   = n;
        found = 1'b1;
      end
    end
    return res;
  endfunction : next_pat

  logic [7:0] fcnt_r;
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      cur_r  <= PAT_WHITE;
      fcnt_r <= 8'h00;
    end else if (psel_wr) begin
      cur_r  <= (PWDATA[7:0] < 8'(NPAT)) ? PWDATA[2:0] : cur_r;
      fcnt_r <= 8'h00;
    end else if (scroll && frame_tick) begin
      if (fcnt_r + 8'h01 >= ir_r[IR_DWELL[3:0]]) begin
        fcnt_r <= 8'h00;
        cur_r  <= next_pat(cur_r, ir_r[IR_PMASK[3:0]]);
      end else begin
        fcnt_r <= fcnt_r + 8'h01;
      end
    end else if (!scroll) begin
      fcnt_r <= 8'h00;
    end
  end

  // ==========================================================================
  // colour generation
  function automatic logic [23:0] pat_color(input logic [2:0] p, input logic [7:0] x,
                                            input logic b, input logic iv);
    logic [7:0]  f;
    logic [7:0]  l;
    logic [23:0] c;
    f = b ? FULL_18 : FULL_24;
    l = b ? {x[5:0], 2'b00} : x;
    case (p)
      PAT_WHITE: c = {f, f, f};
      PAT_RED:   c = {f, 8'h00, 8'h00};
      PAT_GREEN: c = {8'h00, f, 8'h00};
      PAT_BLUE:  c = {8'h00, 8'h00, f};
      PAT_RAMP:  c = {l, l, l};
      default:   c = 24'h000000;
    endcase
    c = iv ? ~c : c;
    return b ? (c & MASK_18) : c;
  endfunction : pat_color

  logic        src_de;
  logic        src_hs;
  logic        src_vs;
  logic [7:0]  src_x;
  assign src_de = tsel ? int_de : VID_IN.de;
  assign src_hs = tsel ? int_hs : VID_IN.hs;
  assign src_vs = tsel ? int_vs : VID_IN.vs;
  assign src_x  = tsel ? int_x : ext_x_r;

  // disabled generator blanks the whole bus rather than leaving stale colour
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      VID_O <= '0;
    end else if (gen_ce) begin
      if (en) begin
        VID_O.de  <= src_de;
        VID_O.hs  <= src_hs;
        VID_O.vs  <= src_vs;
        VID_O.rgb <= src_de ? pat_color(cur_r, src_x, b18, inv) : 24'h000000;
      end else begin
        VID_O <= '0;
      end
    end
  end

  // ==========================================================================
  // assertions
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  sequence s_rd_setup;
    setup && !PWRITE && hit && idx == IDX_IDATA && iaddr_ok && iaddr_r != IR_PSEL;
  endsequence
  sequence s_rd_access;
    acc && PREADY;
  endsequence

  a_clock_source_int: assert property (tsel && !extclk |-> gen_ce == div_ce)
    else $error("internal clock not used");
  a_clock_source_ext: assert property (!tsel |-> gen_ce == PIX_CE)
    else $error("external timing ignored pixel strobe");
  a_int_hsync: assert property (en && tsel && gen_ce && hc_r < ir_r[IR_HSW[3:0]]
    |=> VID_O.hs == !$past(ir_r[IR_SPOL[3:0]][0]))
    else $error("internal hsync wrong");
  a_ext_follow: assert property (en && !tsel && gen_ce
    |=> VID_O.de == $past(VID_IN.de) && VID_O.vs == $past(VID_IN.vs))
    else $error("external timing not followed");
  a_invert_white: assert property (en && inv && !b18 && gen_ce && src_de
    && cur_r == PAT_WHITE |=> VID_O.rgb == 24'h000000)
    else $error("inversion missing");
  a_scroll_cause: assert property ($changed(cur_r) && !$past(psel_wr)
    |-> $past(scroll && frame_tick))
    else $error("pattern advanced without dwell");
  a_scroll_hold: assert property (!scroll && !psel_wr |=> $stable(cur_r))
    else $error("pattern moved with scroll off");
  a_iaddr_write: assert property (wr_iaddr |=> iaddr_r == $past(PWDATA[7:0]))
    else $error("indirect address not stored");
  a_idata_write: assert property (wr_idata && iaddr_ok
    |=> ir_r[$past(iaddr_r[3:0])] == $past(PWDATA[7:0]))
    else $error("indirect write lost");
  a_idata_read: assert property (s_rd_setup ##1 s_rd_access
    |-> PRDATA[7:0] == ir_r[iaddr_r[3:0]])
    else $error("indirect read wrong");
  a_blank_disabled: assert property (!en && gen_ce |=> VID_O.rgb == 24'h000000)
    else $error("output not blank when disabled");
  a_levels_18: assert property (en && b18 && gen_ce |=> (VID_O.rgb & ~MASK_18) == '0)
    else $error("18-bit low bits set");
  a_iaddr_kept: assert property (wr_idata |=> $stable(iaddr_r))
    else $error("data access moved address");
endmodule : vtpc_top
`default_nettype wire

// File: vtpc_pkg.sv
// constants, field layout and carrier types of the video test pattern configuration block
// Function
// - internal timing: clock from pixel clock when source bit set, else divided clock
// - clock-source bit is ignored while external timing is selected
// - timing select set: generate own timing from configuration registers
// - timing select clear: follow incoming pixel clock, data enable and syncs
// - colour-inversion bit set outputs bitwise inverse of each colour value
// - auto-scroll set: advance to next enabled pattern after dwell frame count
// - auto-scroll clear: hold the selected pattern, never advance alone
// - read-write 8-bit indirect address register at index 0x66
// - data write at index 0x67 lands in the indirect register addressed
// - data read at index 0x67 returns the indirect register addressed
// - patterns drive the video outputs only while the enable bit is one
// - 18-bit mode uses 64 levels on six MSBs, else 256 levels
package vtpc_pkg;
  // ==========================================================================
  // register indexes (byte address is four times the index)
  localparam logic [7:0] IDX_ENABLE = 8'h64;
  localparam logic [7:0] IDX_CONFIG = 8'h65;
  localparam logic [7:0] IDX_IADDR  = 8'h66;
  localparam logic [7:0] IDX_IDATA  = 8'h67;
  localparam int unsigned ADDR_W    = 12;
  // ==========================================================================
  // field positions
  localparam int unsigned EN_BIT     = 0;
  localparam int unsigned CFG_B18    = 4;
  localparam int unsigned CFG_EXTCLK = 3;
  localparam int unsigned CFG_TSEL   = 2;
  localparam int unsigned CFG_INV    = 1;
  localparam int unsigned CFG_SCROLL = 0;
  localparam logic [7:0]  CFG_MASK   = 8'h1F;
  // ==========================================================================
  // reset values
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [7:0] RST_IADDR  = 8'h00;
  localparam logic       RST_ENABLE = 1'b0;
  // ==========================================================================
  // indirectly mapped registers
  localparam int unsigned IR_DEPTH = 16;
  localparam logic [7:0] IR_DWELL = 8'h00;
  localparam logic [7:0] IR_PMASK = 8'h01;
  localparam logic [7:0] IR_PSEL  = 8'h02;
  localparam logic [7:0] IR_HTOT  = 8'h03;
  localparam logic [7:0] IR_HACT  = 8'h04;
  localparam logic [7:0] IR_VTOT  = 8'h05;
  localparam logic [7:0] IR_VACT  = 8'h06;
  localparam logic [7:0] IR_HSW   = 8'h07;
  localparam logic [7:0] IR_VSW   = 8'h08;
  localparam logic [7:0] IR_HBP   = 8'h09;
  localparam logic [7:0] IR_VBP   = 8'h0A;
  localparam logic [7:0] IR_SPOL  = 8'h0B;
  localparam logic [7:0] IR_RST [IR_DEPTH] = '{8'h01, 8'h3F, 8'h00, 8'h40, 8'h20,
    8'h30, 8'h18, 8'h04, 8'h02, 8'h04, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  // ==========================================================================
  // patterns and colour
  localparam int unsigned NPAT      = 6;
  localparam logic [2:0]  PAT_WHITE = 3'h0;
  localparam logic [2:0]  PAT_BLACK = 3'h1;
  localparam logic [2:0]  PAT_RED   = 3'h2;
  localparam logic [2:0]  PAT_GREEN = 3'h3;
  localparam logic [2:0]  PAT_BLUE  = 3'h4;
  localparam logic [2:0]  PAT_RAMP  = 3'h5;
  localparam logic [7:0]  FULL_24   = 8'hFF;
  localparam logic [7:0]  FULL_18   = 8'hFC;
  localparam logic [23:0] MASK_18   = 24'hFCFCFC;
  localparam logic [7:0]  DIV_LAST  = 8'h01;
  // ==========================================================================
  typedef struct packed {
    logic        de;
    logic        hs;
    logic        vs;
    logic [23:0] rgb;
  } vtpc_video_t;
endpackage : vtpc_pkg

// File: vtpc_tb.sv
// self-checking testbench of the video test pattern configuration block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import vtpc_pkg::*;
  logic              clk;
  logic              rst;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              pix_ce;
  vtpc_video_t       vid_in;
  vtpc_video_t       vid_o;
  int                errors;
  int                n_tests;

  vtpc_top dut (.CORE_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .PIX_CE(pix_ce), .VID_IN(vid_in), .VID_O(vid_o));

  // ==========================================================================
  // shared helpers
  task automatic conclude();
    if (errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t mismatch got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer, entered just after a rising edge; no wait count is assumed
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [7:0] rd, output logic err);
    int k;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= {24'h000000, wd};
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      errors++;
      $display("ERROR %0t apb transfer never answered", $time);
    end
    rd = prdata[7:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // one idle edge so the next call never re-drives psel in this time step
    @(posedge clk);
  endtask : apb

  task automatic wreg(input logic [7:0] idx, input logic [7:0] val);
    logic [7:0] rd;
    logic       err;
    apb(1'b1, idx, val, rd, err);
  endtask : wreg

  task automatic rreg(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] rd;
    logic       err;
    apb(1'b0, idx, 8'h00, rd, err);
    chk({24'h000000, rd}, {24'h000000, exp});
  endtask : rreg

  task automatic iwr(input logic [7:0] ia, input logic [7:0] val);
    wreg(IDX_IADDR, ia);
    wreg(IDX_IDATA, val);
  endtask : iwr

  // one external pixel: strobe for one cycle, then a quiet cycle
  task automatic pix(input logic de, input logic hs, input logic vs);
    pix_ce <= 1'b1;
    vid_in <= {de, hs, vs, 24'h000000};
    @(posedge clk);
    pix_ce <= 1'b0;
    @(posedge clk);
  endtask : pix

  task automatic frame();
    pix(1'b0, 1'b0, 1'b1);
    pix(1'b0, 1'b0, 1'b0);
    pix(1'b0, 1'b0, 1'b0);
  endtask : frame

  // length in cycles of the next complete high run of one output bit
  task automatic run_len(input bit ext, input int b, output int n);
    int k;
    int st;
    n = 0;
    st = 0;
    for (k = 0; k < 9000 && st < 3; k++) begin
      @(posedge clk);
      if (ext) pix_ce <= ~pix_ce;
      @(negedge clk);
      if (st == 0 && vid_o[b] === 1'b0) st = 1;
      else if (st == 1 && vid_o[b] === 1'b1) begin
        st = 2;
        n = 1;
      end
      else if (st == 2) begin
        if (vid_o[b] === 1'b1) n++;
        else st = 3;
      end
    end
    @(posedge clk);
    pix_ce <= 1'b0;
  endtask : run_len

  // ==========================================================================
  // scenarios
  task automatic t_reset_regs();
    int i;
    rreg(IDX_ENABLE, 8'h00);
    rreg(IDX_CONFIG, 8'h00);
    rreg(IDX_IADDR, 8'h00);
    for (i = 0; i < 12; i++) begin
      wreg(IDX_IADDR, i[7:0]);
      rreg(IDX_IDATA, IR_RST[i]);
    end
    wreg(IDX_CONFIG, 8'hFF);
    rreg(IDX_CONFIG, CFG_MASK);
    wreg(IDX_CONFIG, 8'h00);
  endtask : t_reset_regs

  task automatic t_indirect();
    logic [7:0] rd;
    logic       err;
    iwr(IR_VBP, 8'h5A);
    rreg(IDX_IDATA, 8'h5A);
    rreg(IDX_IDATA, 8'h5A);
    rreg(IDX_IADDR, IR_VBP);
    wreg(IDX_IDATA, 8'h02);
    apb(1'b0, 8'h10, 8'h00, rd, err);
    chk({23'h0, err, rd}, {23'h0, 1'b1, 8'h00});
  endtask : t_indirect

  task automatic t_colours();
    logic [23:0] exp [5];
    int p;
    exp = '{24'hFFFFFF, 24'h000000, 24'hFF0000, 24'h00FF00, 24'h0000FF};
    wreg(IDX_ENABLE, 8'h01);
    for (p = 0; p < 5; p++) begin
      iwr(IR_PSEL, p[7:0]);
      pix(1'b1, 1'b0, 1'b0);
      chk({7'h0, vid_o.de, vid_o.rgb}, {8'h01, exp[p]});
    end
    // ramp: a blank pixel clears the column, the second active pixel is column one
    iwr(IR_PSEL, {5'h00, PAT_RAMP});
    pix(1'b0, 1'b0, 1'b0);
    pix(1'b1, 1'b0, 1'b0);
    pix(1'b1, 1'b0, 1'b0);
    chk({8'h0, vid_o.rgb}, {8'h0, 24'h010101});
    iwr(IR_PSEL, {5'h00, PAT_WHITE});
    wreg(IDX_CONFIG, 8'h02);
    pix(1'b1, 1'b0, 1'b0);
    chk({8'h0, vid_o.rgb}, {8'h0, 24'h000000});
    iwr(IR_PSEL, {5'h00, PAT_RED});
    pix(1'b1, 1'b0, 1'b0);
    chk({8'h0, vid_o.rgb}, {8'h0, 24'h00FFFF});
    wreg(IDX_CONFIG, 8'h10);
    pix(1'b1, 1'b0, 1'b0);
    chk({8'h0, vid_o.rgb}, {8'h0, 24'hFC0000});
    wreg(IDX_CONFIG, 8'h00);
    pix(1'b1, 1'b0, 1'b0);
    // no pixel strobe: the divided clock must not move the output in external timing
    vid_in <= {1'b0, 1'b0, 1'b0, 24'h000000};
    repeat (20) @(posedge clk);
    chk({7'h0, vid_o.de, vid_o.rgb}, {8'h01, 24'hFF0000});
    wreg(IDX_ENABLE, 8'h00);
    pix(1'b1, 1'b0, 1'b0);
    chk({5'h0, vid_o}, 32'h0);
  endtask : t_colours

  task automatic t_scroll();
    wreg(IDX_ENABLE, 8'h01);
    wreg(IDX_CONFIG, 8'h01);
    iwr(IR_DWELL, 8'h02);
    iwr(IR_PMASK, 8'h05);
    iwr(IR_PSEL, PAT_WHITE);
    frame();
    rreg(IDX_IDATA, PAT_WHITE);
    frame();
    rreg(IDX_IDATA, PAT_RED);
    wreg(IDX_CONFIG, 8'h00);
    repeat (4) frame();
    rreg(IDX_IDATA, PAT_RED);
  endtask : t_scroll

  task automatic t_internal();
    int         n;
    int         k;
    vtpc_video_t v0;
    wreg(IDX_ENABLE, 8'h01);
    wreg(IDX_CONFIG, 8'h0C);
    @(negedge clk);
    v0 = vid_o;
    for (k = 0; k < 300; k++) begin
      @(negedge clk);
      if (vid_o !== v0) n = -1;
    end
    chk(n, 0);
    run_len(1'b1, 26, n);
    chk(n, 2 * IR_RST[4]);
    wreg(IDX_CONFIG, 8'h04);
    run_len(1'b0, 26, n);
    chk(n, 2 * IR_RST[4]);
    run_len(1'b0, 25, n);
    chk(n, 2 * IR_RST[7]);
  endtask : t_internal

  // ==========================================================================
  // clock, reset, sequence and watchdog
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    errors = 0;
    n_tests = 0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pix_ce = 1'b0;
    vid_in = '0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset_regs();
    t_indirect();
    t_colours();
    t_scroll();
    t_internal();
    conclude();
  end

  // the tests need some 1.4k cycles; the limit is 50k cycles
  initial begin
    #400000;
    errors++;
    conclude();
  end
endmodule : tb
`default_nettype wire
